// >>> logic/sld_pkg.sv
// Purpose: constants for the supply level detector register bank
// Assumes: AXI4-Lite slave, 32-bit data, one word per register
// Notes: the analog comparator and reference sit outside the block
//
// How it works
// - power enable bit 7 resets zero
// - bit 5 reads comparator output, read only
// - bit 4 reads reference ready while power enable is set, read only
// - rising enable bit 1 flags rising crossings
// - falling enable bit 0 flags falling crossings
// - limit select bits 3:0, read write, resets zero
// - unimplemented bits read zero, ignore writes
// - no flag until enabled and ready
// - reset returns all registers, detector disabled
package sld_pkg;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_LIMIT = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_MASK = 4'hC;
   localparam int BIT_EN = 7;
   localparam int BIT_OUT = 5;
   localparam int BIT_RDY = 4;
   localparam int BIT_RISE = 1;
   localparam int BIT_FALL = 0;
   localparam int BIT_IRQ_DET = 0;
   localparam logic [7:0] CTRL_WMASK = 8'h83;
   localparam logic [3:0] LIMIT_RESET = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sld_pkg

// >>> logic/sld_regs.sv
// Purpose: control and status registers of the supply level detector
// Assumes: comparator and ready inputs synchronous to clk_sys
// Notes: flag is raised on an edge of the comparator output only
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module sld_regs (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // axi4-lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // analog front end
   input wire logic cmp_below,
   input wire logic ref_ready,
   output logic det_power_en,
   output logic [3:0] det_limit_sel,
   // interrupt
   output logic irq
);
   ////////////////////////////////////////////////////////////////////
   logic [1:0] ctrl_dir_r, ctrl_dir_nxt;
   logic en_r, en_nxt;
   logic [3:0] sel_r, sel_nxt;
   logic stat_r, stat_nxt;
   logic mask_r, mask_nxt;
   logic cmp_prev_r, cmp_prev_nxt;
   logic irq_r, irq_nxt;
   logic [3:0] aw_addr_r, aw_addr_nxt;
   logic aw_have_r, aw_have_nxt;
   logic [7:0] w_data_r, w_data_nxt;
   logic w_strb_r, w_strb_nxt;
   logic w_have_r, w_have_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic armed, rise_ev, fall_ev, det_ev, do_wr;
   logic aw_rdy_r, aw_rdy_nxt, w_rdy_r, w_rdy_nxt;
   logic ar_rdy_r, ar_rdy_nxt;
   logic wr_ctrl, wr_limit, wr_clear, wr_bad;

   function automatic logic addr_known(input logic [3:0] a);
      addr_known = (a == sld_pkg::ADDR_CTRL) || (a == sld_pkg::ADDR_LIMIT) ||
                   (a == sld_pkg::ADDR_STATUS) || (a == sld_pkg::ADDR_MASK);
   endfunction : addr_known

   ////////////////////////////////////////////////////////////////////
   // detection: only edges of the comparator count, never its level
   always_comb begin
      armed = en_r && ref_ready;
      rise_ev = armed && cmp_prev_r && !cmp_below && ctrl_dir_r[sld_pkg::BIT_RISE];
      fall_ev = armed && !cmp_prev_r && cmp_below && ctrl_dir_r[sld_pkg::BIT_FALL];
      det_ev = rise_ev || fall_ev;
   end

   ////////////////////////////////////////////////////////////////////
   // bus slave: address and data latch independently, either order
   always_comb begin
      aw_addr_nxt = aw_addr_r;
      aw_have_nxt = aw_have_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      w_have_nxt = w_have_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      en_nxt = en_r;
      ctrl_dir_nxt = ctrl_dir_r;
      sel_nxt = sel_r;
      mask_nxt = mask_r;
      stat_nxt = stat_r;
      cmp_prev_nxt = cmp_below;
      if (s_axi_awvalid && !aw_have_r) begin
         aw_addr_nxt = s_axi_awaddr;
         aw_have_nxt = 1'b1;
      end
      if (s_axi_wvalid && !w_have_r) begin
         w_data_nxt = s_axi_wdata[7:0];
         w_strb_nxt = s_axi_wstrb[0];
         w_have_nxt = 1'b1;
      end
      do_wr = aw_have_r && w_have_r && !bvalid_r;
      if (do_wr) begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = addr_known(aw_addr_r) ? sld_pkg::RESP_OKAY : sld_pkg::RESP_SLVERR;
         if (w_strb_r) begin
            unique case (aw_addr_r)
               sld_pkg::ADDR_CTRL: begin
                  // bits 6, 3, 2 and the read-only bits are dropped
                  en_nxt = w_data_r[sld_pkg::BIT_EN];
                  ctrl_dir_nxt = w_data_r[1:0];
               end
               sld_pkg::ADDR_LIMIT: sel_nxt = w_data_r[3:0];
               sld_pkg::ADDR_STATUS: begin
                  if (w_data_r[sld_pkg::BIT_IRQ_DET]) begin
                     stat_nxt = 1'b0;
                  end
               end
               sld_pkg::ADDR_MASK: mask_nxt = w_data_r[sld_pkg::BIT_IRQ_DET];
               default: begin
               end
            endcase
         end
      end
      // set wins over a clear in the same cycle
      if (det_ev) begin
         stat_nxt = 1'b1;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end else if (s_axi_arvalid && ar_rdy_r) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = addr_known(s_axi_araddr) ? sld_pkg::RESP_OKAY : sld_pkg::RESP_SLVERR;
         rdata_nxt = 32'h0000_0000;
         unique case (s_axi_araddr)
            sld_pkg::ADDR_CTRL: begin
               rdata_nxt[sld_pkg::BIT_EN] = en_r;
               rdata_nxt[sld_pkg::BIT_OUT] = cmp_below;
               rdata_nxt[sld_pkg::BIT_RDY] = en_r && ref_ready;
               rdata_nxt[1:0] = ctrl_dir_r;
            end
            sld_pkg::ADDR_LIMIT: rdata_nxt[3:0] = sel_r;
            sld_pkg::ADDR_STATUS: rdata_nxt[sld_pkg::BIT_IRQ_DET] = stat_r;
            sld_pkg::ADDR_MASK: rdata_nxt[sld_pkg::BIT_IRQ_DET] = mask_r;
            default: begin
            end
         endcase
      end
      // readies are registered so every bus output comes from a flop
      aw_rdy_nxt = !aw_have_nxt;
      w_rdy_nxt = !w_have_nxt;
      // a read is only taken while no answer is pending
      ar_rdy_nxt = !rvalid_nxt;
      irq_nxt = stat_nxt && mask_nxt;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         // every register returns to reset, detector off
         en_r <= 1'b0;
         ctrl_dir_r <= 2'h0;
         sel_r <= sld_pkg::LIMIT_RESET;
         stat_r <= 1'b0;
         mask_r <= 1'b0;
         cmp_prev_r <= 1'b0;
         irq_r <= 1'b0;
         aw_addr_r <= 4'h0;
         aw_have_r <= 1'b0;
         w_data_r <= 8'h00;
         w_strb_r <= 1'b0;
         w_have_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
         rvalid_r <= 1'b0;
         rresp_r <= 2'h0;
         rdata_r <= 32'h0000_0000;
         aw_rdy_r <= 1'b1;
         w_rdy_r <= 1'b1;
         ar_rdy_r <= 1'b1;
      end else begin
         en_r <= en_nxt;
         ctrl_dir_r <= ctrl_dir_nxt;
         sel_r <= sel_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         cmp_prev_r <= cmp_prev_nxt;
         irq_r <= irq_nxt;
         aw_addr_r <= aw_addr_nxt;
         aw_have_r <= aw_have_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         w_have_r <= w_have_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         aw_rdy_r <= aw_rdy_nxt;
         w_rdy_r <= w_rdy_nxt;
         ar_rdy_r <= ar_rdy_nxt;
      end
   end

   assign s_axi_awready = aw_rdy_r;
   assign s_axi_wready = w_rdy_r;
   assign s_axi_arready = ar_rdy_r;

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;
   assign det_power_en = en_r;
   assign det_limit_sel = sel_r;
   assign irq = irq_r;

   ////////////////////////////////////////////////////////////////////
   // write strobes decoded once for the checks below
   always_comb begin
      wr_ctrl = do_wr && w_strb_r && (aw_addr_r == sld_pkg::ADDR_CTRL);
      wr_limit = do_wr && w_strb_r && (aw_addr_r == sld_pkg::ADDR_LIMIT);
      wr_clear = do_wr && w_strb_r && (aw_addr_r == sld_pkg::ADDR_STATUS) &&
                 w_data_r[sld_pkg::BIT_IRQ_DET];
      wr_bad = do_wr && !addr_known(aw_addr_r);
   end

   // flag behaviour
   AST_NO_FLAG_DISARMED: assert property (@(posedge clk_sys) disable iff (srst)
      (!stat_r && !(en_r && ref_ready)) |=> !stat_r)
      else $error("flag set while detector not armed");
   AST_RISE_FLAGS: assert property (@(posedge clk_sys) disable iff (srst)
      rise_ev |=> stat_r)
      else $error("rising crossing not flagged");
   AST_FALL_FLAGS: assert property (@(posedge clk_sys) disable iff (srst)
      fall_ev |=> stat_r)
      else $error("falling crossing not flagged");
   AST_NO_RISE_DISABLED: assert property (@(posedge clk_sys) disable iff (srst)
      (!stat_r && !ctrl_dir_r[sld_pkg::BIT_RISE] && !fall_ev) |=> !stat_r)
      else $error("flag set with no enabled crossing");
   AST_NO_FALL_DISABLED: assert property (@(posedge clk_sys) disable iff (srst)
      (!stat_r && !ctrl_dir_r[sld_pkg::BIT_FALL] && !rise_ev) |=> !stat_r)
      else $error("flag set with falling direction off");
   AST_NEEDS_EDGE: assert property (@(posedge clk_sys) disable iff (srst)
      (!stat_r && $stable(cmp_below)) |=> !stat_r)
      else $error("flag set without a comparator edge");
   AST_STICKY: assert property (@(posedge clk_sys) disable iff (srst)
      (stat_r && !(do_wr && aw_addr_r == sld_pkg::ADDR_STATUS)) |=> stat_r)
      else $error("flag dropped without a clear");
   AST_CLEARED: assert property (@(posedge clk_sys) disable iff (srst)
      (wr_clear && !det_ev) |=> !stat_r)
      else $error("flag not cleared by write of one");
   AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (srst)
      irq == (stat_r && mask_r))
      else $error("interrupt does not match status and mask");

   // register holds and updates
   AST_POWER_FOLLOWS: assert property (@(posedge clk_sys) disable iff (srst)
      wr_ctrl |=> det_power_en == $past(w_data_r[sld_pkg::BIT_EN]))
      else $error("power enable did not follow write");
   AST_POWER_HOLDS: assert property (@(posedge clk_sys) disable iff (srst)
      !wr_ctrl |=> $stable(det_power_en))
      else $error("power enable changed without a write");
   AST_DIR_HOLDS: assert property (@(posedge clk_sys) disable iff (srst)
      !wr_ctrl |=> $stable(ctrl_dir_r))
      else $error("direction enables changed without a write");
   AST_LIMIT_FOLLOWS: assert property (@(posedge clk_sys) disable iff (srst)
      wr_limit |=> det_limit_sel == $past(w_data_r[3:0]))
      else $error("limit select did not follow write");
   AST_LIMIT_HOLDS: assert property (@(posedge clk_sys) disable iff (srst)
      !wr_limit |=> $stable(det_limit_sel))
      else $error("limit select changed without a write");
   AST_BAD_ADDR_ERR: assert property (@(posedge clk_sys) disable iff (srst)
      wr_bad |=> s_axi_bresp == sld_pkg::RESP_SLVERR)
      else $error("unmapped write not refused");

   // read data as first presented
   AST_LIMIT_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (srst)
      (rvalid_r && !$past(rvalid_r) && $past(s_axi_araddr) == sld_pkg::ADDR_LIMIT)
      |-> rdata_r[31:4] == 28'h0000000)
      else $error("limit upper bits not zero");
   AST_CTRL_UNUSED_ZERO: assert property (@(posedge clk_sys) disable iff (srst)
      (rvalid_r && !$past(rvalid_r) && $past(s_axi_araddr) == sld_pkg::ADDR_CTRL)
      |-> rdata_r[31:8] == 24'h000000 && !rdata_r[6] && rdata_r[3:2] == 2'h0)
      else $error("control unused bits not zero");
   AST_OUT_MIRROR: assert property (@(posedge clk_sys) disable iff (srst)
      (rvalid_r && !$past(rvalid_r) && $past(s_axi_araddr) == sld_pkg::ADDR_CTRL)
      |-> rdata_r[sld_pkg::BIT_OUT] == $past(cmp_below))
      else $error("comparator bit does not mirror input");
   AST_RDY_MIRROR: assert property (@(posedge clk_sys) disable iff (srst)
      (rvalid_r && !$past(rvalid_r) && $past(s_axi_araddr) == sld_pkg::ADDR_CTRL)
      |-> rdata_r[sld_pkg::BIT_RDY] == $past(en_r && ref_ready))
      else $error("ready bit does not mirror reference");

   // reset leaves the detector off
   AST_RESET_OFF: assert property (@(posedge clk_sys)
      srst |=> !det_power_en && det_limit_sel == 4'h0 && !irq)
      else $error("reset did not clear detector");
endmodule : sld_regs

// >>> verification/sld_regs_tb.sv
// Purpose: self-checking bench for the supply level detector register bank
// Assumes: comparator and ready inputs are driven synchronously by the bench
// Notes: random data from an 8-bit lfsr seeded with 97
`timescale 1ns/1ps
module sld_regs_tb;
   logic clk_sys = 1'b0, srst = 1'b1;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmp_below = 1'b0, ref_ready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic det_power_en, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [3:0] det_limit_sel;
   logic [7:0] seed = 8'h61;
   int fails = 0, comparisons = 0;
   always #20 clk_sys = ~clk_sys;
   sld_regs u_dut (.clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .cmp_below(cmp_below), .ref_ready(ref_ready),
      .det_power_en(det_power_en), .det_limit_sel(det_limit_sel), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   // control read-back: writable bits kept, ready only while powered
   function automatic logic [31:0] ctrl_exp(input logic [7:0] w, input logic c, input logic r);
      return {24'h0, w[7], 1'b0, c, w[7] & r, 2'b00, w[1:0]};
   endfunction : ctrl_exp
   task automatic test_done;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic hang;
      fails++;
      $display("[ERR] bus wait expected answer seen none");
      test_done();
   endtask : hang
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      if (n == 50) hang();
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      if (n == 50) hang();
      rd_v = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
   endtask : rd
   // disable first, clear flag, configure, then make one crossing
   task automatic ev(input logic [7:0] c, input logic r, input logic from, input logic exp);
      cmp_below <= from;
      ref_ready <= r;
      wr(sld_pkg::ADDR_CTRL, 32'h0);
      wr(sld_pkg::ADDR_STATUS, 32'h1);
      wr(sld_pkg::ADDR_CTRL, {24'h0, c});
      repeat (3) @(posedge clk_sys);
      cmp_below <= ~from;
      repeat (3) @(posedge clk_sys);
      rd(sld_pkg::ADDR_STATUS);
      chk("status", rd_v, {31'h0, exp});
      chk("irq", {31'h0, irq}, {31'h0, exp});
   endtask : ev
   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] ec [8] = '{8'h81, 8'h81, 8'h82, 8'h82, 8'h83, 8'h83, 8'h03, 8'h83};
   logic [7:0] er = 8'b0111_1111, ef = 8'b0010_0110, ex = 8'b0011_0101;
   initial begin
      repeat (6) @(posedge clk_sys);
      srst <= 1'b0;
      for (int i = 0; i < 16; i += 4) begin
         rd(4'(i));
         chk("reset value", rd_v, 32'h0);
      end
      chk("power out", {31'h0, det_power_en}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         wr(sld_pkg::ADDR_CTRL, 32'h0);
         wr(sld_pkg::ADDR_LIMIT, {seed, seed, seed, seed});
         rd(sld_pkg::ADDR_LIMIT);
         chk("limit", rd_v, {28'h0, seed[3:0]});
         chk("limit out", {28'h0, det_limit_sel}, {28'h0, seed[3:0]});
         cmp_below <= seed[5];
         ref_ready <= seed[6];
         wr(sld_pkg::ADDR_CTRL, {24'hFF, seed ^ 8'h7C});
         rd(sld_pkg::ADDR_CTRL);
         chk("control", rd_v, ctrl_exp(seed ^ 8'h7C, seed[5], seed[6]));
         chk("power out", {31'h0, det_power_en}, {31'h0, seed[7]});
      end
      wr(4'h2, 32'hFFFF_FFFF);
      chk("bad write resp", {30'h0, rsp}, {30'h0, sld_pkg::RESP_SLVERR});
      rd(4'h2);
      chk("bad read resp", {30'h0, rsp}, {30'h0, sld_pkg::RESP_SLVERR});
      chk("bad read data", rd_v, 32'h0);
      wr(sld_pkg::ADDR_MASK, 32'h1);
      for (int i = 0; i < 8; i++) ev(ec[i], er[i], ef[i], ex[i]);
      ev(8'h81, 1'b1, 1'b0, 1'b1);
      cmp_below <= 1'b0;
      repeat (10) @(posedge clk_sys);
      rd(sld_pkg::ADDR_STATUS);
      chk("sticky", rd_v, 32'h1);
      wr(sld_pkg::ADDR_MASK, 32'h0);
      repeat (2) @(posedge clk_sys);
      chk("masked irq", {31'h0, irq}, 32'h0);
      wr(sld_pkg::ADDR_STATUS, 32'h1);
      rd(sld_pkg::ADDR_STATUS);
      chk("cleared", rd_v, 32'h0);
      test_done();
   end
endmodule : sld_regs_tb
